// *** hw/gtc_timer.sv ***
// Purpose: Gated 16-bit timer/counter with prescaler, gate, match pair and overflow flag.
// Assumes: CLK is the instruction clock; pin inputs are asynchronous and synchronised here.
// Notes:   Overview of operation
// Overview of operation
// RULE_01: Byte reads of running counter return valid value.
// RULE_02: Software should stop counter before writing bytes.
// RULE_03: Gate source is gate pin or comparator.
// RULE_04: Gate enable ignored when off, else gates counting.
// RULE_05: Gate invert selects active-high or active-low gate.
// RULE_06: Counter wraps to zero and sets overflow flag.
// RULE_07: Interrupt needs overflow, peripheral and global enables.
// RULE_08: Software clears flag in its service routine.
// RULE_09: Overflow wakes sleeping device in asynchronous mode.
// RULE_10: Capture copies count into match pair.
// RULE_11: Compare mode raises event when pair equals count.
// RULE_12: Special event clears count without setting flag.
// RULE_13: Counter byte write beats special event clear.
// RULE_14: Use synchronous mode with special event trigger.
// RULE_15: Counter clock also synchronises comparator output.
// RULE_16: Prescale select divides by one, two, four, eight.
// RULE_17: Low-power oscillator enabled only with internal oscillator.
// RULE_18: No-sync bit matters only for external clock.
// RULE_19: Clock source selects external rising edges or internal.
// RULE_20: Control bit zero starts and stops the counter.
// RULE_21: External falling edge needed before first counted rise.
// RULE_22: Counter byte write clears hidden prescale counter.
// RULE_23: Asynchronous counter keeps counting and flagging in sleep.
// RULE_24: Each prescaler pulse advances count by exactly one.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module gtc_timer
  import gtc_pkg::*;
(
  // Clock and reset.
  input  wire logic              CLK,
  input  wire logic              SRST,
  // Register port.
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  // Asynchronous pins.
  input  wire logic              EXTERNAL_COUNT_INPUT,
  input  wire logic              GATE_PIN,
  input  wire logic              COMPARATOR_OUTPUT,
  // Device state from the same clock domain.
  input  wire logic              SLEEP,
  input  wire logic              INTERNAL_OSCILLATOR_NO_CLKOUT,
  input  wire logic              CAPTURE_EVENT,
  // Outputs.
  output logic                   IRQ,
  output logic                   WAKE,
  output logic                   COMPARE_EVENT,
  output logic                   LOW_POWER_OSC_ENABLE,
  output logic                   COMPARATOR_SYNCED,
  output logic                   COUNT_TICK
);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
    hit = (a == idx);
  endfunction

  function automatic logic [PRESC_W-1:0] presc_last(input logic [1:0] sel);
    presc_last = PRESC_W'((4'h1 << sel) - 4'h1);
  endfunction

  logic [DATA_W-1:0]      timer_one_control;
  logic [DATA_W-1:0]      comparator_config_two;
  logic [CNT_W-1:0]       count;
  logic [CNT_W-1:0]       match;
  logic [DATA_W-1:0]      cc_mode;
  logic                   overflow_flag;
  logic                   overflow_irq_enable;
  logic                   peripheral_irq_enable;
  logic                   global_irq_enable;
  logic [PRESC_W-1:0]     presc_cnt;
  logic [SYNC_INPUTS-1:0] sync_pin;
  logic                   ext_prev;
  logic                   ext_armed;
  logic                   cmp_synced;
  logic                   equal_prev;

  logic counter_on;
  logic clock_source_select;
  logic no_sync_select;
  logic gate_enable;
  logic gate_invert;
  logic gate_source_select;
  logic comparator_sync_enable;
  logic ext_rise;
  logic src_tick;
  logic presc_tick;
  logic gate_raw;
  logic gate_active;
  logic inc_en;
  logic wr_lo;
  logic wr_hi;
  logic cnt_wr;
  logic special_clear;
  logic equal_now;
  logic run_in_sleep;

  assign counter_on             = timer_one_control[CT_ON];
  assign clock_source_select    = timer_one_control[CT_CLK_SRC];
  assign no_sync_select         = timer_one_control[CT_NO_SYNC];
  assign gate_enable            = timer_one_control[CT_GATE_EN];
  assign gate_invert            = timer_one_control[CT_GATE_INV];
  assign gate_source_select     = comparator_config_two[CC_GATE_SRC];
  assign comparator_sync_enable = comparator_config_two[CC_CMP_SYNC];

  // Each pin passes two flip-flops before anything looks at it.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_INPUTS; gi++) begin : g_sync
      logic stage1;
      logic pin_in;
      assign pin_in = (gi == 0) ? EXTERNAL_COUNT_INPUT :
                      (gi == 1) ? GATE_PIN : COMPARATOR_OUTPUT;
      always_ff @(posedge CLK) begin
        if (SRST) begin
          stage1       <= 1'b0;
          sync_pin[gi] <= 1'b0;
        end else begin
          stage1       <= pin_in;
          sync_pin[gi] <= stage1;
        end
      end
    end
  endgenerate

  assign wr_lo  = WR && hit(ADDR, REG_COUNT_LO);
  assign wr_hi  = WR && hit(ADDR, REG_COUNT_HI);
  assign cnt_wr = wr_lo || wr_hi;

  // External edge detect on the second synchroniser stage.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= sync_pin[0];
    end
  end
  assign ext_rise = sync_pin[0] && !ext_prev;

  // A falling edge (a low level seen) must arm the counter before a rise counts;
  // reset, a counter write or switching off disarms it. [RULE_21]
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ext_armed <= 1'b0;
    end else if (cnt_wr || !counter_on) begin
      ext_armed <= 1'b0;
    end else if (!sync_pin[0]) begin
      ext_armed <= 1'b1;
    end
  end

  // Synchronised or internal-clock mode freezes during sleep; unsynchronised external-clock mode keeps counting. [RULE_18] [RULE_23]
  assign run_in_sleep = clock_source_select && no_sync_select;

  // Source clock: external rising edge or every instruction cycle. [RULE_19]
  assign src_tick = counter_on && (!SLEEP || run_in_sleep) &&
                    (clock_source_select ? (ext_rise && ext_armed) : 1'b1);

  // Gate selection, inversion and enable. [RULE_03] [RULE_05] [RULE_04]
  assign gate_raw    = gate_source_select ? sync_pin[1] :
                       (comparator_sync_enable ? cmp_synced : sync_pin[2]);
  assign gate_active = gate_invert ? gate_raw : !gate_raw;

  // Prescaler; a counter write clears it. [RULE_16] [RULE_22]
  always_ff @(posedge CLK) begin
    if (SRST) begin
      presc_cnt <= PRESC_ZERO;
    end else if (cnt_wr) begin
      presc_cnt <= PRESC_ZERO;
    end else if (src_tick) begin
      if (presc_cnt >= presc_last(timer_one_control[CT_PRESC_LO +: 2])) begin
        presc_cnt <= PRESC_ZERO;
      end else begin
        presc_cnt <= presc_cnt + PRESC_ONE;
      end
    end
  end
  assign presc_tick = src_tick &&
                      (presc_cnt >= presc_last(timer_one_control[CT_PRESC_LO +: 2]));
  assign inc_en     = presc_tick && (!gate_enable || gate_active);

  // Comparator output is retimed on the counter's own source clock. [RULE_15]
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cmp_synced <= 1'b0;
    end else if (src_tick) begin
      cmp_synced <= sync_pin[2];
    end
  end

  // Compare match, raised once as the count reaches the pair. [RULE_11]
  assign equal_now = cc_mode[CM_COMPARE] && (count == match);
  always_ff @(posedge CLK) begin
    if (SRST) begin
      equal_prev <= 1'b0;
    end else begin
      equal_prev <= equal_now;
    end
  end
  assign special_clear = equal_now && !equal_prev && cc_mode[CM_SPECIAL];

  // Counter: writes first, then special clear, then increment. [RULE_13] [RULE_12] [RULE_24]
  always_ff @(posedge CLK) begin
    if (SRST) begin
      count <= COUNT_ZERO;
    end else if (wr_lo) begin
      count[7:0] <= WDATA;
    end else if (wr_hi) begin
      count[15:8] <= WDATA;
    end else if (special_clear) begin
      count <= COUNT_ZERO;
    end else if (inc_en) begin
      count <= count + COUNT_ONE; // Wraps from all ones to zero. [RULE_06]
    end
  end

  // Overflow flag: a wrap wins over a software clear. [RULE_06]
  always_ff @(posedge CLK) begin
    if (SRST) begin
      overflow_flag <= 1'b0;
    end else if (inc_en && !cnt_wr && !special_clear && count == COUNT_MAX) begin
      overflow_flag <= 1'b1;
    end else if (WR && hit(ADDR, REG_IRQ_CTRL)) begin
      overflow_flag <= WDATA[IR_FLAG];
    end
  end

  // Match pair: capture takes the live count, otherwise software writes it. [RULE_10]
  always_ff @(posedge CLK) begin
    if (SRST) begin
      match <= COUNT_ZERO;
    end else if (cc_mode[CM_CAPTURE] && CAPTURE_EVENT) begin
      match <= count;
    end else if (WR && hit(ADDR, REG_MATCH_LO)) begin
      match[7:0] <= WDATA;
    end else if (WR && hit(ADDR, REG_MATCH_HI)) begin
      match[15:8] <= WDATA;
    end
  end

  // Configuration registers.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      timer_one_control     <= CONTROL_RESET;
      comparator_config_two <= CMP_CFG_RESET;
      cc_mode               <= ZERO_BYTE;
      overflow_irq_enable   <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      global_irq_enable     <= 1'b0;
    end else if (WR) begin
      if (hit(ADDR, REG_CONTROL)) begin
        timer_one_control <= WDATA; // [RULE_20]
      end else if (hit(ADDR, REG_CMP_CONFIG)) begin
        comparator_config_two <= WDATA & CMP_CFG_MASK;
      end else if (hit(ADDR, REG_CC_MODE)) begin
        cc_mode <= {5'h00, WDATA[CM_SPECIAL:CM_CAPTURE]};
      end else if (hit(ADDR, REG_IRQ_CTRL)) begin
        overflow_irq_enable   <= WDATA[IR_OVF_EN];
        peripheral_irq_enable <= WDATA[IR_PERIPH_EN];
        global_irq_enable     <= WDATA[IR_GLOBAL_EN];
      end
    end
  end

  // Read data stand one cycle after the strobe, zero otherwise; the count is
  // read straight from the live register so each byte is always whole. [RULE_01]
  always_ff @(posedge CLK) begin
    if (SRST || !RD) begin
      RDATA <= ZERO_BYTE;
    end else if (hit(ADDR, REG_CONTROL)) begin
      RDATA <= timer_one_control;
    end else if (hit(ADDR, REG_CMP_CONFIG)) begin
      RDATA <= comparator_config_two;
    end else if (hit(ADDR, REG_COUNT_LO)) begin
      RDATA <= count[7:0];
    end else if (hit(ADDR, REG_COUNT_HI)) begin
      RDATA <= count[15:8];
    end else if (hit(ADDR, REG_MATCH_LO)) begin
      RDATA <= match[7:0];
    end else if (hit(ADDR, REG_MATCH_HI)) begin
      RDATA <= match[15:8];
    end else if (hit(ADDR, REG_IRQ_CTRL)) begin
      RDATA <= {4'h0, global_irq_enable, peripheral_irq_enable,
                overflow_irq_enable, overflow_flag};
    end else begin
      RDATA <= cc_mode;
    end
  end

  // Registered outputs.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      COMPARE_EVENT        <= 1'b0;
      COUNT_TICK           <= 1'b0;
      COMPARATOR_SYNCED    <= 1'b0;
      LOW_POWER_OSC_ENABLE <= 1'b0;
    end else begin
      COMPARE_EVENT        <= equal_now && !equal_prev;
      COUNT_TICK           <= src_tick;
      COMPARATOR_SYNCED    <= cmp_synced;
      // Oscillator only with the internal oscillator and no clock out. [RULE_17]
      LOW_POWER_OSC_ENABLE <= timer_one_control[CT_LP_OSC] && INTERNAL_OSCILLATOR_NO_CLKOUT;
    end
  end

  // Interrupt needs all three enables; wake needs on, overflow and peripheral enables. [RULE_07] [RULE_09]
  assign IRQ  = overflow_flag && overflow_irq_enable && peripheral_irq_enable && global_irq_enable;
  assign WAKE = SLEEP && counter_on && overflow_flag && overflow_irq_enable && peripheral_irq_enable;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_quiet;
    !cnt_wr && !special_clear;
  endsequence

  sequence s_count_read_lo;
    RD && hit(ADDR, REG_COUNT_LO);
  endsequence

  property p_wrap_flag;
    (inc_en && count == COUNT_MAX) and s_quiet |=> count == COUNT_ZERO && overflow_flag;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag"); // [RULE_06]

  property p_irq_gate;
    IRQ |-> overflow_flag && overflow_irq_enable && peripheral_irq_enable && global_irq_enable;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt without all enables"); // [RULE_07]

  property p_special_no_flag;
    special_clear && !cnt_wr && !overflow_flag |=> count == COUNT_ZERO && !overflow_flag;
  endproperty
  a_special_no_flag: assert property (p_special_no_flag) else $error("special clear bad"); // [RULE_12]

  property p_write_wins;
    wr_lo && special_clear |=> count[7:0] == $past(WDATA);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("write lost to special clear"); // [RULE_13]

  property p_off_holds;
    s_quiet ##0 !counter_on |=> $stable(count);
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("count moved while off"); // [RULE_20]

  property p_gate_blocks;
    (counter_on && gate_enable && !gate_active) and s_quiet |=> $stable(count);
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("count moved with gate closed"); // [RULE_04]

  property p_presc_clear;
    cnt_wr |=> presc_cnt == PRESC_ZERO;
  endproperty
  a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared"); // [RULE_22]

  property p_step_one;
    inc_en and s_quiet |=> count == $past(count) + COUNT_ONE;
  endproperty
  a_step_one: assert property (p_step_one) else $error("count did not step by one"); // [RULE_24]

  property p_capture;
    cc_mode[CM_CAPTURE] && CAPTURE_EVENT |=> match == $past(count);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed count"); // [RULE_10]

  property p_unarmed;
    (clock_source_select && !ext_armed) and s_quiet |=> $stable(count);
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("count before falling edge"); // [RULE_21]

  property p_read_lo;
    s_count_read_lo ##0 !WR |=> RDATA == $past(count[7:0]) ##1 RDATA == ZERO_BYTE || $past(RD);
  endproperty
  a_read_lo: assert property (p_read_lo) else $error("low byte read wrong"); // [RULE_01]

  property p_sync_sleep;
    (SLEEP && !run_in_sleep) and s_quiet |=> $stable(count);
  endproperty
  a_sync_sleep: assert property (p_sync_sleep) else $error("synchronised count ran in sleep"); // [RULE_18]

endmodule
`default_nettype wire

// *** hw/gtc_pkg.sv ***
// Purpose: Shared constants for the gated 16-bit timer/counter.
// Assumes: Byte-wide register port with a 3-bit word index.
// Notes:   Register indices, field positions and reset values live here.
package gtc_pkg;
  localparam int          ADDR_W          = 3;
  localparam int          DATA_W          = 8;
  localparam int          CNT_W           = 16;
  localparam int          PRESC_W         = 3;
  // Register indices.
  localparam logic [2:0]  REG_CONTROL     = 3'h0;
  localparam logic [2:0]  REG_CMP_CONFIG  = 3'h1;
  localparam logic [2:0]  REG_COUNT_LO    = 3'h2;
  localparam logic [2:0]  REG_COUNT_HI    = 3'h3;
  localparam logic [2:0]  REG_MATCH_LO    = 3'h4;
  localparam logic [2:0]  REG_MATCH_HI    = 3'h5;
  localparam logic [2:0]  REG_IRQ_CTRL    = 3'h6;
  localparam logic [2:0]  REG_CC_MODE     = 3'h7;
  // Control register fields.
  localparam int          CT_ON           = 0;
  localparam int          CT_CLK_SRC      = 1;
  localparam int          CT_NO_SYNC      = 2;
  localparam int          CT_LP_OSC       = 3;
  localparam int          CT_PRESC_LO     = 4;
  localparam int          CT_GATE_EN      = 6;
  localparam int          CT_GATE_INV     = 7;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  // Comparator configuration fields.
  localparam int          CC_CMP_SYNC     = 0;
  localparam int          CC_GATE_SRC     = 1;
  localparam logic [7:0]  CMP_CFG_RESET   = 8'h02;
  localparam logic [7:0]  CMP_CFG_MASK    = 8'h1B;
  // Interrupt control fields.
  localparam int          IR_FLAG         = 0;
  localparam int          IR_OVF_EN       = 1;
  localparam int          IR_PERIPH_EN    = 2;
  localparam int          IR_GLOBAL_EN    = 3;
  // Capture/compare mode fields.
  localparam int          CM_CAPTURE      = 0;
  localparam int          CM_COMPARE      = 1;
  localparam int          CM_SPECIAL      = 2;
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;
  localparam logic [15:0] COUNT_MAX       = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO      = 16'h0000;
  localparam logic [15:0] COUNT_ONE       = 16'h0001;
  localparam logic [2:0]  PRESC_ZERO      = 3'h0;
  localparam logic [2:0]  PRESC_ONE       = 3'h1;
  localparam int          SYNC_INPUTS     = 3;
endpackage

// *** tb/gtc_far_side.sv ***
// Purpose: Far-side model: count clock source, gate pin, comparator and capture unit.
// Assumes: The bench calls its tasks; every change follows a rising CLK edge.
// Notes:   The count clock idles high between bursts, as a stopped source would.
`timescale 1ns/1ps
`default_nettype none
module gtc_far_side (
  // Clock.
  input  wire logic CLK,
  // Pins towards the timer.
  output var  logic EXT_CLK,
  output var  logic GATE,
  output var  logic CMP,
  output var  logic CAPTURE
);
  initial begin
    EXT_CLK = 1'b1;
    GATE    = 1'b0;
    CMP     = 1'b0;
    CAPTURE = 1'b0;
  end
  // Four-cycle half periods keep every edge visible through the two-flop synchroniser.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge CLK);
      EXT_CLK <= 1'b0;
      repeat (4) @(posedge CLK);
      EXT_CLK <= 1'b1;
      repeat (3) @(posedge CLK);
    end
  endtask
  task automatic levels(input logic g, input logic c);
    @(posedge CLK);
    GATE <= g;
    CMP  <= c;
  endtask
  task automatic capture();
    @(posedge CLK);
    CAPTURE <= 1'b1;
    @(posedge CLK);
    CAPTURE <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/gtc_timer_tb.sv ***
// Purpose: Self-checking bench for the gated 16-bit timer/counter.
// Assumes: Register port reads answer one cycle after the strobe.
// Notes:   Counts under the internal clock are checked within one tick in the prescaler test, within wider spans in the gate, overflow and compare tests.
`timescale 1ns/1ps
`default_nettype none
module gtc_timer_tb;
  import gtc_pkg::*;
  logic              clk, srst, wr, rd, ext_clk, gate, cmp, cap, sleep, osc_mode;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic              irq, wake, cmp_ev, lp_en, cmp_sync, tick;
  int                err_total, samples_checked, cycles;

  gtc_timer dut (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .EXTERNAL_COUNT_INPUT(ext_clk), .GATE_PIN(gate), .COMPARATOR_OUTPUT(cmp),
    .SLEEP(sleep), .INTERNAL_OSCILLATOR_NO_CLKOUT(osc_mode), .CAPTURE_EVENT(cap), .IRQ(irq),
    .WAKE(wake), .COMPARE_EVENT(cmp_ev), .LOW_POWER_OSC_ENABLE(lp_en),
    .COMPARATOR_SYNCED(cmp_sync), .COUNT_TICK(tick));
  gtc_far_side far (.CLK(clk), .EXT_CLK(ext_clk), .GATE(gate), .CMP(cmp), .CAPTURE(cap));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      $display("BAD %0t run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_span(input logic [15:0] got, input int lo, input int hi);
    samples_checked++;
    if ((got inside {[lo:hi]}) !== 1'b1) begin
      err_total++;
      $display("BAD %0t value %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rd_count(output logic [15:0] c);
    rd_reg(REG_COUNT_LO, c[7:0]);
    rd_reg(REG_COUNT_HI, c[15:8]);
  endtask
  task automatic restart(input logic [15:0] v);
    wr_reg(REG_CONTROL, ZERO_BYTE);
    wr_reg(REG_COUNT_LO, v[7:0]);
    wr_reg(REG_COUNT_HI, v[15:8]);
  endtask

  task automatic t_reset();
    logic [7:0] d;
    rd_reg(REG_CONTROL, d);
    chk_byte(d, 8'h00);
    rd_reg(REG_CMP_CONFIG, d);
    chk_byte(d, 8'h02);
    wr_reg(REG_CMP_CONFIG, 8'hFF);
    rd_reg(REG_CMP_CONFIG, d);
    chk_byte(d, 8'h1B);
    wr_reg(REG_CMP_CONFIG, 8'h02);
  endtask

  task automatic t_prescale();
    logic [15:0] c, e;
    for (int ps = 0; ps < 4; ps++) begin
      restart(COUNT_ZERO);
      wr_reg(REG_CONTROL, 8'(ps << CT_PRESC_LO) | 8'h01);
      repeat (62) @(posedge clk);
      wr_reg(REG_CONTROL, 8'(ps << CT_PRESC_LO));
      rd_count(c);
      chk_span(c, (64 >> ps) - 1, (64 >> ps) + 1);
    end
    repeat (10) @(posedge clk);
    rd_count(e);
    chk_span(e, int'(c), int'(c));
  endtask

  task automatic t_gate();
    logic [15:0] c;
    logic        lev;
    for (int i = 0; i < 8; i++) begin
      wr_reg(REG_CMP_CONFIG, {6'h00, i[2], 1'b0});
      far.levels(i[0], !i[0]);
      restart(COUNT_ZERO);
      wr_reg(REG_CONTROL, {i[1], 7'h41});
      repeat (20) @(posedge clk);
      wr_reg(REG_CONTROL, ZERO_BYTE);
      rd_count(c);
      lev = i[2] ? i[0] : !i[0];
      if (lev == i[1]) chk_span(c, 19, 25);
      else chk_span(c, 0, 0);
    end
    wr_reg(REG_CMP_CONFIG, CMP_CFG_RESET);
  endtask

  task automatic t_external();
    logic [15:0] c;
    restart(COUNT_ZERO);
    wr_reg(REG_CONTROL, 8'h03);
    far.pulses(5);
    repeat (6) @(posedge clk);
    rd_count(c);
    chk_span(c, 5, 5);
    @(posedge clk);
    sleep <= 1'b1;
    far.pulses(3);
    repeat (6) @(posedge clk);
    rd_count(c);
    chk_span(c, 5, 5);
    wr_reg(REG_CONTROL, 8'h07);
    far.pulses(3);
    repeat (6) @(posedge clk);
    rd_count(c);
    chk_span(c, 8, 8);
    @(posedge clk);
    sleep <= 1'b0;
  endtask

  task automatic t_overflow();
    logic [15:0] c;
    logic [7:0]  d;
    wr_reg(REG_IRQ_CTRL, 8'h06);
    restart(16'hFFFD);
    wr_reg(REG_CONTROL, 8'h01);
    repeat (8) @(posedge clk);
    wr_reg(REG_CONTROL, ZERO_BYTE);
    rd_count(c);
    chk_span(c, 4, 10);
    rd_reg(REG_IRQ_CTRL, d);
    chk_byte(d, 8'h07);
    chk_bit(irq, 1'b0);
    @(posedge clk);
    sleep <= 1'b1;
    wr_reg(REG_CONTROL, 8'h01);
    #1;
    chk_bit(wake, 1'b1);
    @(posedge clk);
    sleep <= 1'b0;
    wr_reg(REG_CONTROL, ZERO_BYTE);
    wr_reg(REG_IRQ_CTRL, 8'h0D);
    #1;
    chk_bit(irq, 1'b0);
    wr_reg(REG_IRQ_CTRL, 8'h0F);
    #1;
    chk_bit(irq, 1'b1);
    wr_reg(REG_IRQ_CTRL, 8'h0E);
    #1;
    chk_bit(irq, 1'b0);
  endtask

  task automatic t_compare();
    logic [15:0] c;
    logic [7:0]  d;
    int          n, t0, t1;
    n = 0;
    t0 = 0;
    t1 = 0;
    wr_reg(REG_IRQ_CTRL, ZERO_BYTE);
    restart(COUNT_ZERO);
    wr_reg(REG_MATCH_LO, 8'h10);
    wr_reg(REG_MATCH_HI, ZERO_BYTE);
    wr_reg(REG_CC_MODE, 8'h06);
    wr_reg(REG_CONTROL, 8'h01);
    for (int k = 0; k < 60; k++) begin
      @(posedge clk);
      #1;
      if (cmp_ev === 1'b1) begin
        n++;
        t0 = (n == 1) ? k : t0;
        t1 = (n == 2) ? k : t1;
      end
    end
    wr_reg(REG_CONTROL, ZERO_BYTE);
    chk_span(16'(n), 3, 4);
    chk_span(16'(t1 - t0), 17, 17);
    rd_count(c);
    chk_span(c, 0, 16);
    rd_reg(REG_IRQ_CTRL, d);
    chk_byte(d, ZERO_BYTE);
    restart(COUNT_ZERO);
    wr_reg(REG_CONTROL, 8'h01);
    repeat (15) @(posedge clk);
    // The write lands in the very cycle that the count sits on the match value.
    wr_reg(REG_COUNT_LO, 8'h55);
    wr_reg(REG_CONTROL, ZERO_BYTE);
    rd_count(c);
    chk_span(c, 'h57, 'h57);
    wr_reg(REG_CC_MODE, 8'h01);
    restart(16'h1234);
    far.capture();
    rd_reg(REG_MATCH_LO, d);
    chk_byte(d, 8'h34);
    rd_reg(REG_MATCH_HI, d);
    chk_byte(d, 8'h12);
  endtask

  task automatic t_side_outputs();
    @(posedge clk);
    osc_mode <= 1'b1;
    wr_reg(REG_CONTROL, 8'h08);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(lp_en, 1'b1);
    @(posedge clk);
    osc_mode <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_bit(lp_en, 1'b0);
    wr_reg(REG_CMP_CONFIG, 8'h01);
    wr_reg(REG_CONTROL, 8'h01);
    far.levels(1'b0, 1'b1);
    repeat (8) @(posedge clk);
    #1;
    chk_bit(cmp_sync, 1'b1);
    chk_bit(tick, 1'b1);
    far.levels(1'b0, 1'b0);
    repeat (8) @(posedge clk);
    #1;
    chk_bit(cmp_sync, 1'b0);
    wr_reg(REG_CONTROL, ZERO_BYTE);
    @(posedge clk);
    #1;
    chk_bit(tick, 1'b0);
  endtask

  initial begin
    srst            = 1'b1;
    wr              = 1'b0;
    rd              = 1'b0;
    addr            = '0;
    wdata           = '0;
    sleep           = 1'b0;
    osc_mode        = 1'b0;
    err_total       = 0;
    samples_checked = 0;
    cycles          = 0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_prescale();
    t_gate();
    t_external();
    t_overflow();
    t_compare();
    t_side_outputs();
    tally_and_finish();
  end
endmodule
`default_nettype wire
